// file: uls_pkg.sv
// Shared constants for the line status block: register map, field positions, sizes.
package uls_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam int unsigned ADDR_W           = 8;
   localparam logic [7:0]  ADDR_LINE_STATUS = 8'h00;
   localparam logic [7:0]  ADDR_CTRL        = 8'h04;
   localparam logic [7:0]  ADDR_EVENT       = 8'h08;
   localparam logic [7:0]  ADDR_MASK        = 8'h0C;

   ////////////////////////////////////////////////////////////////////////////
   // Line status bit positions
   localparam int unsigned LS_FIFO_ERR   = 7;
   localparam int unsigned LS_TX_EMPTY   = 6;
   localparam int unsigned LS_HOLD_EMPTY = 5;
   localparam int unsigned LS_BREAK      = 4;
   localparam int unsigned LS_STOP_ERR   = 3;
   localparam int unsigned REG_W         = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Control register layout and reset value
   localparam int unsigned CTRL_IRQ_MODE  = 0;
   localparam int unsigned CTRL_FIFO_EN   = 1;
   localparam int unsigned CTRL_FRAME_LSB = 4;
   localparam int unsigned FRAME_W        = 4;
   localparam logic [7:0]  CTRL_RESET     = 8'hA0;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky event bits, same layout in the mask register
   localparam int unsigned EVT_BREAK    = 0;
   localparam int unsigned EVT_STOP_ERR = 1;
   localparam int unsigned EVT_FIFO_ERR = 2;
   localparam int unsigned EVT_HOLD     = 3;
   localparam int unsigned EVT_W        = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Per-character receive flags and receive FIFO size
   localparam int unsigned FLG_PAR   = 0;
   localparam int unsigned FLG_STOP  = 1;
   localparam int unsigned FLG_BRK   = 2;
   localparam int unsigned FLG_W     = 3;
   localparam int unsigned RX_DEPTH  = 128;
   localparam int unsigned PTR_W     = 7;
   localparam int unsigned CNT_W     = 8;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite encodings
   localparam logic       HRESP_OKAY = 1'h0;

   typedef enum logic [1:0] {
      ULS_BRK_IDLE = 2'h0,
      ULS_BRK_LOW  = 2'h1,
      ULS_BRK_HELD = 2'h3
   } uls_brk_state_t;

   function automatic logic uls_any_err(input logic [FLG_W-1:0] flags);
      return |flags;
   endfunction

endpackage

// file: uls_err_tracker.sv
// Shadow of the receive FIFO error flags with a count of flagged characters.
`timescale 1ns/100ps
module uls_err_tracker
   import uls_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             push,
   input  wire logic [FLG_W-1:0] pushFlags,
   input  wire logic             pop,
   output logic      [FLG_W-1:0] topFlags,
   output logic                  errPresent
);

   logic [FLG_W-1:0] flagMem [RX_DEPTH];
   logic [PTR_W-1:0] wrPtr_reg;
   logic [PTR_W-1:0] rdPtr_reg;
   logic [CNT_W-1:0] fill_reg;
   logic [CNT_W-1:0] errCnt_reg;

   wire empty    = (fill_reg == '0);
   wire full     = (fill_reg == CNT_W'(RX_DEPTH));
   wire doPush   = push & ~full;
   wire doPop    = pop & ~empty;
   wire pushErr  = doPush & uls_any_err(pushFlags);
   wire popErr   = doPop & uls_any_err(flagMem[rdPtr_reg]);

   // Counting flagged entries lets the summary clear exactly when the last one leaves
   wire [CNT_W-1:0] errCnt_next = errCnt_reg + CNT_W'(pushErr) - CNT_W'(popErr);
   wire [CNT_W-1:0] fill_next   = fill_reg + CNT_W'(doPush) - CNT_W'(doPop);

   assign topFlags   = empty ? '0 : flagMem[rdPtr_reg];
   assign errPresent = (errCnt_reg != '0); // [RQ2] [RQ3]

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtr_reg  <= '0;
         rdPtr_reg  <= '0;
         fill_reg   <= '0;
         errCnt_reg <= '0;
      end else begin
         wrPtr_reg  <= wrPtr_reg + PTR_W'(doPush);
         rdPtr_reg  <= rdPtr_reg + PTR_W'(doPop);
         fill_reg   <= fill_next;
         errCnt_reg <= errCnt_next;
      end
   end

   // Flag storage needs no reset: an entry is only read after it was written
   always_ff @(posedge clk) begin
      if (doPush) begin
         flagMem[wrPtr_reg] <= pushFlags;
      end
   end

endmodule

// file: uls_line_status.sv
// Line status, break detection and interrupt pin drive of the UART, on an AHB-Lite slave.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RQ1] Interrupt pin driven push-pull when drive mode bit is 0, open-source when 1.
// [RQ2] FIFO error summary sets while any stored character has parity, framing or break.
// [RQ3] FIFO error summary clears only when no remaining stored character is flagged.
// [RQ4] Non-FIFO: transmitter empty while holding and shift registers are both empty.
// [RQ5] FIFO mode: transmitter empty only when transmit FIFO and shift register empty.
// [RQ6] Non-FIFO: holding empty sets on move to shifter, clears on CPU load.
// [RQ7] FIFO mode: holding empty sets when FIFO empties, clears on first written byte.
// [RQ8] Interrupt requested while holding empty and its transmit interrupt enable set.
// [RQ9] Break bit set once the receive line stays low for a whole frame.
// [RQ10] One break character per break condition, however long the line stays low.
// [RQ11] After reset the error summary, break and framing bits read zero.
// [RQ12] Framing bit reports a missing stop bit for the character at FIFO top.
// [RQ13] CPU reads line status and writes characters only when holding space exists.
module uls_line_status
   import uls_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   // AHB-Lite slave
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   // Receiver side
   input  wire logic             rxLine,
   input  wire logic             rxBitTick,
   input  wire logic             rxPush,
   input  wire logic [FLG_W-1:0] rxPushFlags,
   input  wire logic             rxPop,
   output logic                  brkCharPush,
   // Transmitter side
   input  wire logic             txLoad,
   input  wire logic             txToShift,
   input  wire logic             txFifoEmpty,
   input  wire logic             txShiftEmpty,
   input  wire logic             txHoldIntEn,
   // Interrupt pin
   output logic                  irqOut,
   output logic                  irqOe
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [REG_W-1:0]   ctrl_reg;
   logic [EVT_W-1:0]   event_reg;
   logic [EVT_W-1:0]   mask_reg;
   logic               wrPend_reg;
   logic [ADDR_W-1:0]  wrAddr_reg;
   logic [31:0]        hrdata_reg;
   logic               hreadyout_reg;
   logic               hresp_reg;

   logic               holdEmpty_reg;
   logic               txEmpty_reg;
   logic               fifoErr_reg;
   logic [FLG_W-1:0]   topFlags_reg;

   uls_brk_state_t     brkState_reg;
   uls_brk_state_t     brkState_next;
   logic [FRAME_W-1:0] brkCnt_reg;
   logic [FRAME_W-1:0] brkCnt_next;
   logic               brkPush_reg;
   logic               brkFire;

   logic               irqOut_reg;
   logic               irqOe_reg;

   logic [FLG_W-1:0]   topFlags;
   logic               errPresent;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode

   wire addrPhase  = hsel & hready & htrans[1];
   wire [ADDR_W-1:0] addrLow = haddr[ADDR_W-1:0];
   wire rdNow      = addrPhase & ~hwrite;
   wire wrCtrl     = wrPend_reg & (wrAddr_reg == ADDR_CTRL);
   wire wrEvent    = wrPend_reg & (wrAddr_reg == ADDR_EVENT);
   wire wrMask     = wrPend_reg & (wrAddr_reg == ADDR_MASK);

   wire irqMode    = ctrl_reg[CTRL_IRQ_MODE];
   wire fifoMode   = ctrl_reg[CTRL_FIFO_EN];
   wire [FRAME_W-1:0] frameBits = ctrl_reg[CTRL_FRAME_LSB +: FRAME_W];

   ////////////////////////////////////////////////////////////////////////////
   // Transmit status

   // A load in the same cycle as a move to the shifter leaves the holding stage full,
   // so the load has the last word in both modes
   wire holdSet    = fifoMode ? txFifoEmpty : txToShift; // [RQ6] [RQ7]
   wire holdEmpty_next = txLoad ? 1'b0 : (holdSet ? 1'b1 : holdEmpty_reg); // [RQ6] [RQ7]
   wire txEmpty_next   = holdEmpty_next & txShiftEmpty; // [RQ4] [RQ5]

   ////////////////////////////////////////////////////////////////////////////
   // Break detection

   wire lineLow    = ~rxLine;
   wire [FRAME_W-1:0] brkCntInc = brkCnt_reg + FRAME_W'(1);
   wire frameDone  = rxBitTick & (brkCntInc == frameBits) & (frameBits != '0);

   always_comb begin
      brkState_next = brkState_reg;
      brkCnt_next   = brkCnt_reg;
      brkFire       = 1'b0;
      unique case (brkState_reg)
         ULS_BRK_IDLE: begin
            brkCnt_next = '0;
            if (lineLow) begin
               brkState_next = ULS_BRK_LOW;
            end
         end
         ULS_BRK_LOW: begin
            if (!lineLow) begin
               brkState_next = ULS_BRK_IDLE;
            end else if (frameDone) begin
               brkFire       = 1'b1; // [RQ9]
               brkState_next = ULS_BRK_HELD;
            end else if (rxBitTick) begin
               brkCnt_next = brkCntInc;
            end
         end
         ULS_BRK_HELD: begin
            // Stay here until the line returns high so a long break loads one character
            brkCnt_next = '0;
            if (!lineLow) begin
               brkState_next = ULS_BRK_IDLE; // [RQ10]
            end
         end
         default: begin
            brkState_next = ULS_BRK_IDLE;
            brkCnt_next   = '0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive flag tracking

   wire trkPush = rxPush | brkPush_reg;
   wire [FLG_W-1:0] brkFlags = brkPush_reg ? FLG_W'(1 << FLG_BRK) : '0;
   wire [FLG_W-1:0] trkFlags = (rxPush ? rxPushFlags : '0) | brkFlags; // [RQ10]

   uls_err_tracker u_tracker (
      .clk        (clk),
      .rst        (rst),
      .push       (trkPush),
      .pushFlags  (trkFlags),
      .pop        (rxPop),
      .topFlags   (topFlags),
      .errPresent (errPresent)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Line status word and events

   wire [REG_W-1:0] lineStatus = (REG_W'(fifoErr_reg) << LS_FIFO_ERR)             // [RQ2]
                               | (REG_W'(txEmpty_reg) << LS_TX_EMPTY)             // [RQ4]
                               | (REG_W'(holdEmpty_reg) << LS_HOLD_EMPTY)         // [RQ6]
                               | (REG_W'(topFlags_reg[FLG_BRK]) << LS_BREAK)      // [RQ9]
                               | (REG_W'(topFlags_reg[FLG_STOP]) << LS_STOP_ERR); // [RQ12]

   wire [EVT_W-1:0] evtSet = (EVT_W'(brkFire) << EVT_BREAK)
                           | (EVT_W'(topFlags[FLG_STOP] & ~topFlags_reg[FLG_STOP])
                              << EVT_STOP_ERR)
                           | (EVT_W'(errPresent & ~fifoErr_reg) << EVT_FIFO_ERR)
                           | (EVT_W'(holdEmpty_next & ~holdEmpty_reg) << EVT_HOLD);
   wire [EVT_W-1:0] evtClr = wrEvent ? hwdata[EVT_W-1:0] : '0;
   // An event arriving with its clear is kept
   wire [EVT_W-1:0] event_next = (event_reg & ~evtClr) | evtSet;

   wire irqNow = (holdEmpty_reg & txHoldIntEn) | (|(event_reg & mask_reg)); // [RQ8]
   // Open-source mode releases the pin while idle; the board pulls it low
   wire irqOe_next  = irqMode ? irqNow : 1'b1; // [RQ1]

   wire [REG_W-1:0] rdSel = (addrLow == ADDR_LINE_STATUS) ? lineStatus
                          : (addrLow == ADDR_CTRL)        ? ctrl_reg
                          : (addrLow == ADDR_EVENT)       ? REG_W'(event_reg)
                          : (addrLow == ADDR_MASK)        ? REG_W'(mask_reg)
                          : '0;

   ////////////////////////////////////////////////////////////////////////////
   // Bus registers

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPend_reg <= 1'b0;
      end else begin
         wrPend_reg <= addrPhase & hwrite;
      end
   end

   // Upper address bits are not decoded, so the map repeats every 256 bytes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrAddr_reg <= '0;
      end else begin
         wrAddr_reg <= addrLow;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata_reg <= '0;
      end else begin
         hrdata_reg <= rdNow ? 32'(rdSel) : '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hreadyout_reg <= 1'b0;
      end else begin
         hreadyout_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hresp_reg <= HRESP_OKAY;
      end else begin
         hresp_reg <= HRESP_OKAY;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
      end else begin
         ctrl_reg <= wrCtrl ? hwdata[REG_W-1:0] : ctrl_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_reg <= '0;
      end else begin
         event_reg <= event_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mask_reg <= '0;
      end else begin
         mask_reg <= wrMask ? hwdata[EVT_W-1:0] : mask_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status registers

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         holdEmpty_reg <= 1'b1;
      end else begin
         holdEmpty_reg <= holdEmpty_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txEmpty_reg <= 1'b1;
      end else begin
         txEmpty_reg <= txEmpty_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         fifoErr_reg <= 1'b0; // [RQ11]
      end else begin
         fifoErr_reg <= errPresent;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         topFlags_reg <= '0; // [RQ11]
      end else begin
         topFlags_reg <= topFlags;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         brkState_reg <= ULS_BRK_IDLE;
      end else begin
         brkState_reg <= brkState_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         brkCnt_reg <= '0;
      end else begin
         brkCnt_reg <= brkCnt_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         brkPush_reg <= 1'b0;
      end else begin
         brkPush_reg <= brkFire;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt pin

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqOut_reg <= 1'b0;
      end else begin
         irqOut_reg <= irqNow;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqOe_reg <= 1'b1;
      end else begin
         irqOe_reg <= irqOe_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign hrdata      = hrdata_reg;
   assign hreadyout   = hreadyout_reg;
   assign hresp       = hresp_reg;
   assign brkCharPush = brkPush_reg;
   assign irqOut      = irqOut_reg;
   assign irqOe       = irqOe_reg;

endmodule

// file: uls_line_status_props.sv
// Concurrent checks on the ports of the line status block.
`timescale 1ns/100ps
module uls_line_status_props
   import uls_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   input  wire logic        hreadyout,
   input  wire logic        hresp,
   input  wire logic        rxLine,
   input  wire logic        rxBitTick,
   input  wire logic        brkCharPush,
   input  wire logic        txLoad,
   input  wire logic        txToShift,
   input  wire logic        txFifoEmpty,
   input  wire logic        txShiftEmpty,
   input  wire logic        txHoldIntEn,
   input  wire logic        irqOut,
   input  wire logic        irqOe
);
   logic rdTake;
   logic brkArmed;

   assign rdTake = hsel && hready && htrans[1] && !hwrite;

   // Remembers a reported break until the line is seen idle again
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         brkArmed <= 1'b0;
      else
         brkArmed <= brkCharPush | (brkArmed & !rxLine);
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence rdStatus;
      rdTake && haddr[7:0] == ADDR_LINE_STATUS;
   endsequence

   sequence holdRefill;
      txToShift && txFifoEmpty && !txLoad ##1 txHoldIntEn && !txLoad;
   endsequence

   irq_drive_a: assert property (!irqOe |-> !irqOut)
      else $error("interrupt level high while pin released");
   hold_irq_a: assert property (holdRefill |=> irqOut)
      else $error("no interrupt after holding stage emptied");
   tx_busy_a: assert property (!txShiftEmpty ##1 rdStatus |=> !hrdata[LS_TX_EMPTY])
      else $error("transmitter empty shown while shifter busy");
   hold_load_a: assert property (txLoad ##1 rdStatus |=> !hrdata[LS_HOLD_EMPTY])
      else $error("holding empty shown after a load");
   brk_cause_a: assert property (brkCharPush |-> $past(rxBitTick) && !$past(rxLine))
      else $error("break request without a low line tick");
   brk_once_a: assert property (brkCharPush |-> !brkArmed)
      else $error("second break request in one low period");
   rdata_idle_a: assert property (!$past(rdTake) |-> hrdata == 32'h0)
      else $error("read data outside a data phase");
   bus_okay_a: assert property (hresp == HRESP_OKAY && (!$past(hreadyout) || hreadyout))
      else $error("wait state or error response");
endmodule

bind uls_line_status uls_line_status_props u_props (.*);

// file: uls_host_model.sv
// Host processor model: single-word bus master and guarded character writes.
`timescale 1ns/100ps
module uls_host_model
   import uls_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        hreadyout,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   output logic             txLoad
);
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, txLoad} = '0;
      hsize = 3'h2;
   end

   // Waits on ready without a cycle count; only the bench watchdog ends a hang
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= wr ? wd : 32'h0;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask

   task send(output logic ok);
      logic [31:0] s;
      xfer(1'b0, ADDR_LINE_STATUS, 32'h0, s);
      ok = s[LS_HOLD_EMPTY];
      if (ok === 1'b1) begin
         txLoad <= 1'b1;
         @(posedge clk);
         txLoad <= 1'b0;
      end
   endtask
endmodule

// file: uls_line_status_test.sv
// Self-checking bench for the line status block.
`timescale 1ns/100ps
module uls_line_status_test
   import uls_pkg::*;
   ;
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] data;
   } uls_row_t;
   logic             clk, rst, hsel, hwrite, hready, hreadyout, hresp, ok;
   logic [31:0]      haddr, hwdata, hrdata, rd;
   logic [1:0]       htrans, tickCnt;
   logic [2:0]       hsize;
   logic             rxLine, rxBitTick, rxPush, rxPop, brkCharPush, tbPush;
   logic [FLG_W-1:0] rxPushFlags, tbFlags;
   logic             txLoad, txToShift, txFifoEmpty, txShiftEmpty, txHoldIntEn;
   logic             irqOut, irqOe;
   int               err_count, cmp_count, brkCount;
   uls_row_t         rows [12];

   assign hready      = hreadyout;
   assign rxPush      = tbPush;
   assign rxPushFlags = tbFlags;

   uls_line_status DUT (.*);
   uls_host_model  host (.*);

   initial clk = 1'b0;
   always #50 clk = ~clk;

   // Receiver stand-in: free bit tick; the block stores its own break entry
   always @(posedge clk) begin
      if (rst) begin
         tickCnt   <= 2'h0;
         rxBitTick <= 1'b0;
      end else begin
         tickCnt   <= tickCnt + 2'h1;
         rxBitTick <= (tickCnt == 2'h3);
      end
      brkCount <= brkCount + int'(brkCharPush === 1'b1);
   end

   ////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task rdChk(input logic [7:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, rd);
      check(rd, exp);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd);
   endtask
   task rxOp(input logic isPush, input logic [FLG_W-1:0] f);
      tbFlags <= f;
      tbPush  <= isPush;
      rxPop   <= !isPush;
      @(posedge clk);
      {tbPush, rxPop} <= 2'h0;
      @(posedge clk);
   endtask
   task shiftPulse;
      txToShift <= 1'b1;
      @(posedge clk);
      txToShift <= 1'b0;
      @(posedge clk);
   endtask
   task irqChk(input logic [31:0] exp);
      repeat (2) @(posedge clk);
      check({30'h0, irqOe, irqOut}, exp);
   endtask
   task results;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Whole run is under a thousand cycles; thirty thousand means a hang
   initial begin
      #3000000;
      err_count++;
      results();
   end

   initial begin
      {rst, rxLine, txFifoEmpty, txShiftEmpty} = 4'hF;
      {rxPop, tbPush, tbFlags, txToShift, txHoldIntEn} = '0;
      rows = '{'{1'b0, ADDR_CTRL, {24'h0, CTRL_RESET}}, '{1'b0, ADDR_LINE_STATUS, 32'h60},
               '{1'b0, ADDR_EVENT, 32'h0}, '{1'b0, ADDR_MASK, 32'h0},
               '{1'b1, ADDR_LINE_STATUS, 32'hFF}, '{1'b0, ADDR_LINE_STATUS, 32'h60},
               '{1'b1, 8'h10, 32'h12345678}, '{1'b0, 8'h10, 32'h0},
               '{1'b1, ADDR_CTRL, 32'hFFFFFF40}, '{1'b0, ADDR_CTRL, 32'h40},
               '{1'b1, ADDR_MASK, 32'h5}, '{1'b0, ADDR_MASK, 32'h5}};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      foreach (rows[i])
         if (rows[i].wr) wr(rows[i].addr, rows[i].data);
         else rdChk(rows[i].addr, rows[i].data);
      txHoldIntEn <= 1'b1;
      irqChk(32'h3);
      txShiftEmpty <= 1'b0;
      host.send(ok);
      check({31'h0, ok}, 32'h1);
      rdChk(ADDR_LINE_STATUS, 32'h00);
      irqChk(32'h2);
      host.send(ok);
      check({31'h0, ok}, 32'h0);
      shiftPulse();
      rdChk(ADDR_LINE_STATUS, 32'h20);
      irqChk(32'h3);
      txShiftEmpty <= 1'b1;
      @(posedge clk);
      rdChk(ADDR_LINE_STATUS, 32'h60);
      wr(ADDR_CTRL, 32'h42);
      {txFifoEmpty, txShiftEmpty} <= 2'h0;
      host.send(ok);
      rdChk(ADDR_LINE_STATUS, 32'h00);
      shiftPulse();
      rdChk(ADDR_LINE_STATUS, 32'h00);
      txFifoEmpty <= 1'b1;
      @(posedge clk);
      rdChk(ADDR_LINE_STATUS, 32'h20);
      txShiftEmpty <= 1'b1;
      @(posedge clk);
      rdChk(ADDR_LINE_STATUS, 32'h60);
      wr(ADDR_CTRL, 32'h41);
      irqChk(32'h3);
      txHoldIntEn <= 1'b0;
      irqChk(32'h0);
      wr(ADDR_CTRL, 32'h40);
      wr(ADDR_EVENT, 32'hF);
      wr(ADDR_MASK, 32'h4);
      rxOp(1'b1, 3'h1);
      rxOp(1'b1, 3'h0);
      rxOp(1'b1, 3'h2);
      rdChk(ADDR_LINE_STATUS, 32'hE0);
      rxOp(1'b0, 3'h0);
      rdChk(ADDR_LINE_STATUS, 32'hE0);
      rxOp(1'b0, 3'h0);
      rdChk(ADDR_LINE_STATUS, 32'hE8);
      rxOp(1'b0, 3'h0);
      rdChk(ADDR_LINE_STATUS, 32'h60);
      rdChk(ADDR_EVENT, 32'h6);
      irqChk(32'h3);
      wr(ADDR_EVENT, 32'h4);
      rdChk(ADDR_EVENT, 32'h2);
      irqChk(32'h2);
      rxLine <= 1'b0;
      repeat (40) @(posedge clk);
      check(brkCount, 32'h1);
      rdChk(ADDR_LINE_STATUS, 32'hF0);
      rxLine <= 1'b1;
      rxOp(1'b0, 3'h0);
      rdChk(ADDR_LINE_STATUS, 32'h60);
      rdChk(ADDR_EVENT, 32'h7);
      // A zero frame length must keep break detection off
      wr(ADDR_CTRL, 32'h0);
      rxLine <= 1'b0;
      repeat (40) @(posedge clk);
      check(brkCount, 32'h1);
      rxLine <= 1'b1;
      rst    <= 1'b1;
      repeat (2) @(posedge clk);
      check({30'h0, irqOe, irqOut}, 32'h2);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rdChk(ADDR_LINE_STATUS, 32'h60);
      rdChk(ADDR_EVENT, 32'h0);
      rdChk(ADDR_CTRL, {24'h0, CTRL_RESET});
      results();
   end
endmodule
